// file: hw/intercom_call_control_pkg.sv
package intercom_call_control_pkg;

    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned MIN_PRESS_MS = 300;
    localparam int unsigned VOL_SHORT_MS = 2000;
    localparam int unsigned LONG_PRESS_MS = 3000;
    localparam int unsigned BLINK_MS     = 250;
    localparam int unsigned MS_CYCLES    = CLK_MHZ * 1000;

    localparam logic [31:0] MIN_PRESS_CYC  = 32'(MIN_PRESS_MS * MS_CYCLES);
    localparam logic [31:0] VOL_SHORT_CYC  = 32'(VOL_SHORT_MS * MS_CYCLES);
    localparam logic [31:0] LONG_PRESS_CYC = 32'(LONG_PRESS_MS * MS_CYCLES);
    localparam logic [31:0] BLINK_CYC      = 32'(BLINK_MS * MS_CYCLES);

    localparam int unsigned LEVEL_W = 4;
    localparam logic [3:0]  LEVEL_MAX = 4'hf;
    localparam logic [3:0]  SEL_IC    = 4'ha;
    localparam logic [3:0]  SEL_DUAL  = 4'h9;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_CONFIG = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_LEVELS = 12'h00c;

    localparam int unsigned CFG_CALL_TONE_EN  = 0;
    localparam int unsigned CFG_CABIN_ISO_EN  = 1;
    localparam int unsigned CFG_VOX_KNOB_EN   = 2;
    localparam int unsigned CFG_ECALL_EN      = 3;
    localparam int unsigned CFG_SCALL_FMON_EN = 4;
    localparam int unsigned CFG_SCALL_CH_LSB  = 8;
    localparam logic [31:0] CONFIG_RESET      = 32'h0000_000d;

    localparam int unsigned CTRL_COCKPIT_PRESS = 0;
    localparam int unsigned CTRL_CABIN_PRESS   = 1;

    typedef enum logic [1:0] {CONNECTED, ISOLATED, CALLING} link_e;

endpackage : intercom_call_control_pkg

// file: hw/intercom_call_control.sv
// Functional notes
// RL1 - Cockpit press toggles connected and isolated
// RL2 - Cockpit LED lit while isolated
// RL3 - Cabin press in isolation enters call
// RL4 - Cockpit press in call reconnects circuits
// RL5 - Second cabin press cancels call
// RL6 - Call tone while blinking unless disabled
// RL7 - Cabin press ignored while connected
// RL8 - Cabin isolation option only disconnects
// RL9 - Voice intercom active in positions 1-8, dual
// RL10 - Knob enables voice intercom, configurable
// RL11 - Intercom position: mic only with PTT
// RL12 - External hot-mike switch opens microphone
// RL13 - Keyed transmitter suspends local intercom
// RL14 - Threshold short press raises one step
// RL15 - Threshold long press restores panel value
// RL16 - Volume short press raises one step
// RL17 - Volume long press restores panel value
// RL18 - Panel change discards winchman adjustments
// RL19 - Emergency call tone, configurable
// RL20 - Selective call assigned to one channel
// RL21 - Assigned LED blinks at double rate
// RL22 - Forced monitoring during selective call
// RL23 - Too-short and mid volume presses ignored
//
// The AXI4-Lite register port and the register offsets were decided locally.
module intercom_call_control (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        cockpitButton,
    input  wire logic        cabinButton,
    input  wire logic [3:0]  txSelector,
    input  wire logic        voxKnobReleased,
    input  wire logic        pttHeld,
    input  wire logic        hotMikeSwitch,
    input  wire logic        txKeyed,
    input  wire logic        winchVoxButton,
    input  wire logic        winchVolButton,
    input  wire logic [3:0]  panelVoxLevel,
    input  wire logic [3:0]  panelVolume,
    input  wire logic        emergencyCallIn,
    input  wire logic        selectiveCallIn,
    input  wire logic [7:0]  monitorSelect,
    input  wire logic [7:0]  channelLedIn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             circuitsConnected,
    output logic             cockpitLed,
    output logic             cabinLed,
    output logic             callTone,
    output logic             emergencyTone,
    output logic             voxEnable,
    output logic             micToIntercom,
    output logic [3:0]       voxLevel,
    output logic [3:0]       headsetVolume,
    output logic [7:0]       channelLed,
    output logic [7:0]       monitorOut
);

    typedef struct packed {
        intercom_call_control_pkg::link_e link;
        logic        cockpitPrev;
        logic        cabinPrev;
        logic        voxPrev;
        logic        volPrev;
        logic [31:0] voxCnt;
        logic [31:0] volCnt;
        logic [31:0] blinkCnt;
        logic        slowBlink;
        logic        fastBlink;
        logic [3:0]  voxLvl;
        logic [3:0]  volLvl;
        logic [3:0]  panelVoxPrev;
        logic [3:0]  panelVolPrev;
        logic [31:0] cfgReg;
        logic        swCockpit;
        logic        swCabin;
        logic        awDone;
        logic        wDone;
        logic [11:0] awAddr;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        awRdy;
        logic        wRdy;
        logic        arRdy;
        logic        bValid;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  bResp;
        logic [1:0]  rResp;
        logic        conn;
        logic        ckLed;
        logic        cbLed;
        logic        cTone;
        logic        eTone;
        logic        voxEn;
        logic        mic;
        logic [7:0]  chLed;
        logic [7:0]  mon;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;

    // Saturating one-step increase shared by both winchman controls
    function automatic logic [3:0] stepUp(input logic [3:0] v);
        stepUp = (v == intercom_call_control_pkg::LEVEL_MAX) ? v : v + 4'h1;
    endfunction : stepUp

    function automatic logic [31:0] satInc(input logic [31:0] c);
        satInc = (c == 32'hffff_ffff) ? c : c + 32'h1;
    endfunction : satInc

    logic       cockpitPress;
    logic       cabinPress;
    logic       panelChanged;
    logic [2:0] scallCh;
    logic       wrFire;
    logic [11:0] wrAddr;
    logic [31:0] wrData;
    logic       voxRel;
    logic       volRel;

    always_comb begin
        nxt_cur = cur_ff;
        cockpitPress = (cockpitButton && !cur_ff.cockpitPrev) || cur_ff.swCockpit;
        cabinPress = (cabinButton && !cur_ff.cabinPrev) || cur_ff.swCabin;
        scallCh = cur_ff.cfgReg[intercom_call_control_pkg::CFG_SCALL_CH_LSB +: 3]; // [RL20]
        nxt_cur.cockpitPrev = cockpitButton;
        nxt_cur.cabinPrev = cabinButton;
        nxt_cur.swCockpit = 1'b0;
        nxt_cur.swCabin = 1'b0;

        case (cur_ff.link)
            intercom_call_control_pkg::CONNECTED: begin
                if (cockpitPress) begin
                    nxt_cur.link = intercom_call_control_pkg::ISOLATED; // [RL1]
                end else if (cabinPress
                        && cur_ff.cfgReg[intercom_call_control_pkg::CFG_CABIN_ISO_EN]) begin
                    nxt_cur.link = intercom_call_control_pkg::ISOLATED; // [RL7] [RL8]
                end
            end
            intercom_call_control_pkg::ISOLATED: begin
                if (cockpitPress) begin
                    nxt_cur.link = intercom_call_control_pkg::CONNECTED; // [RL1]
                end else if (cabinPress) begin
                    nxt_cur.link = intercom_call_control_pkg::CALLING; // [RL3] [RL8]
                end
            end
            intercom_call_control_pkg::CALLING: begin
                if (cockpitPress) begin
                    nxt_cur.link = intercom_call_control_pkg::CONNECTED; // [RL4]
                end else if (cabinPress) begin
                    nxt_cur.link = intercom_call_control_pkg::ISOLATED; // [RL5]
                end
            end
            default: begin
                nxt_cur.link = intercom_call_control_pkg::CONNECTED;
            end
        endcase

        // Shared blink timebase; fast phase toggles twice per slow phase
        if (cur_ff.blinkCnt >= (intercom_call_control_pkg::BLINK_CYC >> 1) - 32'h1) begin
            nxt_cur.blinkCnt = 32'h0;
            nxt_cur.fastBlink = !cur_ff.fastBlink; // [RL21]
            if (cur_ff.fastBlink) begin
                nxt_cur.slowBlink = !cur_ff.slowBlink;
            end
        end else begin
            nxt_cur.blinkCnt = cur_ff.blinkCnt + 32'h1;
        end

        nxt_cur.conn = (nxt_cur.link == intercom_call_control_pkg::CONNECTED);
        nxt_cur.ckLed = !nxt_cur.conn; // [RL2]
        case (nxt_cur.link)
            intercom_call_control_pkg::CALLING: nxt_cur.cbLed = nxt_cur.slowBlink; // [RL3]
            intercom_call_control_pkg::ISOLATED: nxt_cur.cbLed = 1'b1; // [RL5]
            default: nxt_cur.cbLed = 1'b0; // [RL4]
        endcase
        nxt_cur.cTone = (nxt_cur.link == intercom_call_control_pkg::CALLING)
            && cur_ff.cfgReg[intercom_call_control_pkg::CFG_CALL_TONE_EN]; // [RL6]
        nxt_cur.eTone = emergencyCallIn
            && cur_ff.cfgReg[intercom_call_control_pkg::CFG_ECALL_EN]; // [RL19]

        // Voice intercom in channel and dual positions, knob may be bypassed
        nxt_cur.voxEn = (txSelector >= 4'h1) && (txSelector <= intercom_call_control_pkg::SEL_DUAL)
            && (voxKnobReleased || !cur_ff.cfgReg[intercom_call_control_pkg::CFG_VOX_KNOB_EN])
            && !txKeyed; // [RL9] [RL10] [RL13]
        nxt_cur.mic = !txKeyed && (hotMikeSwitch
            || (txSelector == intercom_call_control_pkg::SEL_IC && pttHeld)); // [RL11] [RL12] [RL13]

        // Winchman press timing measured at release
        voxRel = !winchVoxButton && cur_ff.voxPrev;
        volRel = !winchVolButton && cur_ff.volPrev;
        nxt_cur.voxPrev = winchVoxButton;
        nxt_cur.volPrev = winchVolButton;
        nxt_cur.voxCnt = winchVoxButton ? satInc(cur_ff.voxCnt) : 32'h0;
        nxt_cur.volCnt = winchVolButton ? satInc(cur_ff.volCnt) : 32'h0;
        if (voxRel) begin
            if (cur_ff.voxCnt >= intercom_call_control_pkg::LONG_PRESS_CYC) begin
                nxt_cur.voxLvl = panelVoxLevel; // [RL15]
            end else if (cur_ff.voxCnt >= intercom_call_control_pkg::MIN_PRESS_CYC) begin
                nxt_cur.voxLvl = stepUp(cur_ff.voxLvl); // [RL14] [RL23]
            end
        end
        if (volRel) begin
            if (cur_ff.volCnt >= intercom_call_control_pkg::LONG_PRESS_CYC) begin
                nxt_cur.volLvl = panelVolume; // [RL17]
            end else if (cur_ff.volCnt >= intercom_call_control_pkg::MIN_PRESS_CYC
                    && cur_ff.volCnt <= intercom_call_control_pkg::VOL_SHORT_CYC) begin
                nxt_cur.volLvl = stepUp(cur_ff.volLvl); // [RL16] [RL23]
            end
        end
        panelChanged = (panelVoxLevel != cur_ff.panelVoxPrev)
            || (panelVolume != cur_ff.panelVolPrev);
        nxt_cur.panelVoxPrev = panelVoxLevel;
        nxt_cur.panelVolPrev = panelVolume;
        if (panelChanged) begin
            nxt_cur.voxLvl = panelVoxLevel; // [RL18]
            nxt_cur.volLvl = panelVolume; // [RL18]
        end

        nxt_cur.chLed = channelLedIn;
        nxt_cur.mon = monitorSelect;
        if (selectiveCallIn) begin
            nxt_cur.chLed[scallCh] = cur_ff.fastBlink; // [RL21]
            if (cur_ff.cfgReg[intercom_call_control_pkg::CFG_SCALL_FMON_EN]) begin
                nxt_cur.mon[scallCh] = 1'b1; // [RL22]
            end
        end

        // AXI4-Lite slave: address and data taken in either order
        if (s_axi_awvalid && !cur_ff.awDone && !cur_ff.bValid) begin
            nxt_cur.awDone = 1'b1;
            nxt_cur.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_ff.wDone && !cur_ff.bValid) begin
            nxt_cur.wDone = 1'b1;
            nxt_cur.wData = s_axi_wdata;
            // Strobes kept: master may drop them once data is taken
            nxt_cur.wStrb = s_axi_wstrb;
        end
        wrFire = nxt_cur.awDone && nxt_cur.wDone && !cur_ff.bValid;
        wrAddr = nxt_cur.awAddr;
        wrData = nxt_cur.wData;
        if (wrFire) begin
            nxt_cur.awDone = 1'b0;
            nxt_cur.wDone = 1'b0;
            nxt_cur.bValid = 1'b1;
            nxt_cur.bResp = 2'h0;
            if (wrAddr == intercom_call_control_pkg::ADDR_CTRL) begin
                nxt_cur.swCockpit = wrData[intercom_call_control_pkg::CTRL_COCKPIT_PRESS];
                nxt_cur.swCabin = wrData[intercom_call_control_pkg::CTRL_CABIN_PRESS];
            end else if (wrAddr == intercom_call_control_pkg::ADDR_CONFIG) begin
                for (int i = 0; i < 4; i++) begin
                    if (nxt_cur.wStrb[i]) begin
                        nxt_cur.cfgReg[8*i +: 8] = wrData[8*i +: 8];
                    end
                end
            end else if (wrAddr != intercom_call_control_pkg::ADDR_STATUS
                    && wrAddr != intercom_call_control_pkg::ADDR_LEVELS) begin
                nxt_cur.bResp = 2'h2;
            end
        end else if (cur_ff.bValid && s_axi_bready) begin
            nxt_cur.bValid = 1'b0;
        end
        if (s_axi_arvalid && !cur_ff.rValid) begin
            nxt_cur.rValid = 1'b1;
            nxt_cur.rResp = 2'h0;
            case (s_axi_araddr)
                intercom_call_control_pkg::ADDR_CTRL: nxt_cur.rData = 32'h0;
                intercom_call_control_pkg::ADDR_CONFIG: nxt_cur.rData = cur_ff.cfgReg;
                intercom_call_control_pkg::ADDR_STATUS: nxt_cur.rData = {26'h0,
                    cur_ff.eTone, cur_ff.cTone, cur_ff.mic, cur_ff.voxEn, cur_ff.link};
                intercom_call_control_pkg::ADDR_LEVELS: nxt_cur.rData = {24'h0,
                    cur_ff.volLvl, cur_ff.voxLvl};
                default: begin
                    nxt_cur.rData = 32'h0;
                    nxt_cur.rResp = 2'h2;
                end
            endcase
        end else if (cur_ff.rValid && s_axi_rready) begin
            nxt_cur.rValid = 1'b0;
        end

        if (srst) begin
            nxt_cur = '0;
            nxt_cur.link = intercom_call_control_pkg::CONNECTED;
            nxt_cur.cfgReg = intercom_call_control_pkg::CONFIG_RESET;
            nxt_cur.conn = 1'b1;
        end
        // Readies follow next state so they leave a flip-flop with no added latency
        nxt_cur.awRdy = !nxt_cur.awDone && !nxt_cur.bValid;
        nxt_cur.wRdy = !nxt_cur.wDone && !nxt_cur.bValid;
        nxt_cur.arRdy = !nxt_cur.rValid;
    end

    always_ff @(posedge clk) begin
        cur_ff <= nxt_cur;
    end

    assign s_axi_awready = cur_ff.awRdy;
    assign s_axi_wready  = cur_ff.wRdy;
    assign s_axi_bvalid  = cur_ff.bValid;
    assign s_axi_bresp   = cur_ff.bResp;
    assign s_axi_arready = cur_ff.arRdy;
    assign s_axi_rvalid  = cur_ff.rValid;
    assign s_axi_rdata   = cur_ff.rData;
    assign s_axi_rresp   = cur_ff.rResp;
    assign circuitsConnected = cur_ff.conn;
    assign cockpitLed    = cur_ff.ckLed;
    assign cabinLed      = cur_ff.cbLed;
    assign callTone      = cur_ff.cTone;
    assign emergencyTone = cur_ff.eTone;
    assign voxEnable     = cur_ff.voxEn;
    assign micToIntercom = cur_ff.mic;
    assign voxLevel      = cur_ff.voxLvl;
    assign headsetVolume = cur_ff.volLvl;
    assign channelLed    = cur_ff.chLed;
    assign monitorOut    = cur_ff.mon;

    a_cockpit_led: assert property (@(posedge clk) disable iff (srst) // [RL2]
        cockpitLed == !circuitsConnected) else $error("Cockpit LED mismatch");

    a_cockpit_toggle: assert property (@(posedge clk) disable iff (srst) // [RL1]
        (cockpitButton && !cur_ff.cockpitPrev
         && cur_ff.link == intercom_call_control_pkg::ISOLATED)
        |=> ##1 circuitsConnected) else $error("Cockpit press did not reconnect");

    a_cabin_ignored: assert property (@(posedge clk) disable iff (srst) // [RL7]
        (cur_ff.link == intercom_call_control_pkg::CONNECTED && !cockpitPress && !cur_ff.swCockpit
         && !cur_ff.cfgReg[intercom_call_control_pkg::CFG_CABIN_ISO_EN])
        |=> cur_ff.link == intercom_call_control_pkg::CONNECTED)
        else $error("Cabin press changed connected state");

    a_cabin_call: assert property (@(posedge clk) disable iff (srst) // [RL3]
        (cur_ff.link == intercom_call_control_pkg::ISOLATED && cabinPress && !cockpitPress)
        |=> cur_ff.link == intercom_call_control_pkg::CALLING)
        else $error("Cabin press did not enter call");

    a_call_cancel: assert property (@(posedge clk) disable iff (srst) // [RL5]
        (cur_ff.link == intercom_call_control_pkg::CALLING && cabinPress && !cockpitPress)
        |=> ##1 cabinLed) else $error("Call cancel left LED dark");

    a_call_reconnect: assert property (@(posedge clk) disable iff (srst) // [RL4]
        (cur_ff.link == intercom_call_control_pkg::CALLING && cockpitPress)
        |=> ##1 !cabinLed && circuitsConnected) else $error("Call not answered");

    // Tone was registered from the setting one cycle earlier
    a_call_tone: assert property (@(posedge clk) disable iff (srst) // [RL6]
        callTone |-> cur_ff.link == intercom_call_control_pkg::CALLING
        && $past(cur_ff.cfgReg[intercom_call_control_pkg::CFG_CALL_TONE_EN]))
        else $error("Call tone outside call");

    a_tx_priority: assert property (@(posedge clk) disable iff (srst) // [RL13]
        txKeyed |=> !voxEnable && !micToIntercom) else $error("Intercom during transmit");

    a_ecall_tone: assert property (@(posedge clk) disable iff (srst) // [RL19]
        emergencyCallIn && cur_ff.cfgReg[intercom_call_control_pkg::CFG_ECALL_EN]
        |=> emergencyTone) else $error("Emergency tone missing");

    a_panel_reset: assert property (@(posedge clk) disable iff (srst) // [RL18]
        (panelVolume != cur_ff.panelVolPrev) |=> headsetVolume == $past(panelVolume))
        else $error("Panel change kept winchman volume");

    a_scall_monitor: assert property (@(posedge clk) disable iff (srst) // [RL22]
        selectiveCallIn && cur_ff.cfgReg[intercom_call_control_pkg::CFG_SCALL_FMON_EN]
        |=> monitorOut[$past(scallCh)]) else $error("Forced monitor missing");

endmodule : intercom_call_control

// file: sim/operator_panel_model.sv
module operator_panel_model (
    input  wire logic       clk,
    input  wire logic [1:0] pressReq,
    output logic            cockpitButton,
    output logic            cabinButton
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] holdCnt = 3'h0;
    logic       which   = 1'b0;
    // A hand holds the button several cycles, so the design must act on the edge only
    always @(posedge clk) begin
        if (pressReq != 2'h0) begin
            which   <= pressReq[1];
            holdCnt <= 3'h4;
        end else if (holdCnt != 3'h0) begin
            holdCnt <= holdCnt - 3'h1;
        end
    end
    assign cockpitButton = (holdCnt != 3'h0) && !which;
    assign cabinButton   = (holdCnt != 3'h0) && which;
endmodule : operator_panel_model

// file: sim/test_intercom_call_control.sv
module test_intercom_call_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, srst = 1'b1, voxKnobReleased = 1'b0, pttHeld = 1'b0;
    logic        hotMikeSwitch = 1'b0, txKeyed = 1'b0, emergencyCallIn = 1'b0;
    logic        selectiveCallIn = 1'b0, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0, winchVoxButton = 1'b0, winchVolButton = 1'b0;
    logic [1:0]  pressReq = 2'h0, resp;
    logic [3:0]  txSelector = 4'h0, panelVoxLevel = 4'h0, panelVolume = 4'h0;
    logic [7:0]  monitorSelect = 8'h00, channelLedIn = 8'h00, mask;
    logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
    logic [31:0] wData = 32'h0, cfg = 32'h0000_000d, rnd = 32'h0000_679d, got;
    wire logic   cockpitButton, cabinButton, awReady, wReady, bValid, arReady, rValid;
    wire logic   circuitsConnected, cockpitLed, cabinLed, callTone, emergencyTone;
    wire logic   voxEnable, micToIntercom;
    wire logic [1:0]  bResp, rResp;
    wire logic [3:0]  voxLevel, headsetVolume;
    wire logic [7:0]  channelLed, monitorOut;
    wire logic [31:0] rData;
    int          fail_count = 0, compares = 0, cycles = 0, link = 0;
    int          ops[12] = '{1, 0, 1, 1, 1, 0, 1, 1, 1, 0, 1, 1};

    operator_panel_model partner (.clk, .pressReq, .cockpitButton, .cabinButton);
    intercom_call_control dut (.clk, .srst, .cockpitButton, .cabinButton, .txSelector,
        .voxKnobReleased, .pttHeld, .hotMikeSwitch, .txKeyed, .winchVoxButton,
        .winchVolButton, .panelVoxLevel, .panelVolume, .emergencyCallIn,
        .selectiveCallIn, .monitorSelect, .channelLedIn, .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .circuitsConnected, .cockpitLed, .cabinLed, .callTone,
        .emergencyTone, .voxEnable, .micToIntercom, .voxLevel, .headsetVolume,
        .channelLed, .monitorOut);

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // Hang guard: whole run needs about 700 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nextRnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (n < 100) begin
            @(posedge clk);
            n++;
            if (awValid && awReady === 1'b1) awValid <= 1'b0;
            if (wValid && wReady === 1'b1) wValid <= 1'b0;
            if (bValid === 1'b1) begin
                r = bResp;
                n = 1000;
            end
        end
        if (n != 1000) fail_count++;
        bReady <= 1'b0;
        @(posedge clk);
    endtask : axiWrite

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        d = 32'h0;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (n < 100) begin
            @(posedge clk);
            n++;
            if (arValid && arReady === 1'b1) arValid <= 1'b0;
            if (rValid === 1'b1) begin
                d = rData;
                r = rResp;
                n = 1000;
            end
        end
        if (n != 1000) fail_count++;
        rReady <= 1'b0;
        @(posedge clk);
    endtask : axiRead

    task automatic checkLink();
        check(circuitsConnected, link == 0, "connected");
        check(cockpitLed, link != 0, "cockpit led");
        // Blink phase is unknown at call entry, so cabin LED only judged when steady
        if (link != 2) check(cabinLed, link == 1, "cabin led");
        check(callTone, link == 2 && cfg[0], "call tone");
        axiRead(intercom_call_control_pkg::ADDR_STATUS, got, resp);
        check(got[1:0], link, "status link");
    endtask : checkLink

    task automatic press(input int which);
        pressReq[which] <= 1'b1;
        @(posedge clk);
        pressReq <= 2'h0;
        repeat (8) @(posedge clk);
        if (which == 0) link = (link == 0) ? 1 : 0;
        else link = (link == 1) ? 2 : (link == 2) ? 1 : (cfg[1] ? 1 : 0);
        checkLink();
    endtask : press

    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check(circuitsConnected, 1'b1, "reset link");
        check(cockpitLed, 1'b0, "reset led");
        axiRead(intercom_call_control_pkg::ADDR_CONFIG, got, resp);
        check(got, intercom_call_control_pkg::CONFIG_RESET, "config reset");
        axiRead(12'h010, got, resp);
        check(resp, 2'h2, "unmapped read");
        axiWrite(12'h020, 32'h1, resp);
        check(resp, 2'h2, "unmapped write");
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            if (i == 6) begin
                cfg = 32'h0000_051e;
                axiWrite(intercom_call_control_pkg::ADDR_CONFIG, cfg, resp);
            end
            press(ops[i]);
        end
        axiWrite(intercom_call_control_pkg::ADDR_CTRL, 32'h1, resp);
        link = 0;
        checkLink();
        axiWrite(intercom_call_control_pkg::ADDR_CTRL, 32'h2, resp);
        link = 1;
        checkLink();
        $display("test isolate and call done");
        for (int k = 0; k < 128; k++) begin
            if (k == 64) begin
                cfg = 32'h0000_0512;
                axiWrite(intercom_call_control_pkg::ADDR_CONFIG, cfg, resp);
            end
            rnd = nextRnd(rnd);
            txSelector <= rnd[3:0];
            txKeyed <= rnd[4];
            voxKnobReleased <= rnd[5];
            pttHeld <= rnd[6];
            hotMikeSwitch <= rnd[7];
            emergencyCallIn <= rnd[8];
            selectiveCallIn <= rnd[9];
            monitorSelect <= rnd[17:10];
            channelLedIn <= rnd[25:18];
            // Winchman presses here are far below the shortest valid press
            winchVoxButton <= rnd[11];
            winchVolButton <= rnd[12];
            if (rnd[26]) panelVoxLevel <= rnd[30:27];
            if (rnd[31]) panelVolume <= rnd[29:26];
            repeat (4) @(posedge clk);
            check(voxEnable, txSelector >= 4'h1 && txSelector <= 4'h9 && !txKeyed
                  && (!cfg[2] || voxKnobReleased), "vox");
            check(micToIntercom, !txKeyed && (hotMikeSwitch || (txSelector == 4'ha
                  && pttHeld)), "mic");
            check(emergencyTone, emergencyCallIn && cfg[3], "ecall");
            check(monitorOut, monitorSelect | ((selectiveCallIn && cfg[4])
                  ? (8'h01 << cfg[10:8]) : 8'h00), "monitor");
            mask = selectiveCallIn ? ~(8'h01 << cfg[10:8]) : 8'hff;
            check(channelLed & mask, channelLedIn & mask, "channel led");
            check(voxLevel, panelVoxLevel, "vox level");
            check(headsetVolume, panelVolume, "volume");
        end
        $display("test intercom modes done");
        conclude();
    end
endmodule : test_intercom_call_control
